/* adc_dac_serial_pin_logic.sv */
`timescale 1ns/1ps
`include "adc_dac_pins_cfg.svh"

// What this block does
// [RQ1] modes 00, 01, 10 move the serial output on falling clock edges
// [RQ2] mode 11 moves the serial output on rising clock edges
// [RQ3] serial output is released whenever chip select is high; here the enable trails chip select by three mclk cycles
// [RQ4] serial input is sampled on every falling serial clock edge while chip select is low
// [RQ5] serial port works only while chip select is low
// [RQ6] end-of-conversion output is active low; results valid after it falls
// [RQ7] dac load input acts apart from the serial clock and updates outputs
// [RQ8] while dac load is low, written codes pass straight to dac outputs
// [RQ9] wake select pin picks dac power-up level: low ground, high reference
// [RQ10] outside party requests an external conversion by pulling the request low
// [RQ11] chip select fall starts a frame; rise resets the serial port
// [RQ12] each frame opens with an msb-first command byte, then data bytes
// [RQ13] master keeps serial clock at 25 MHz or less, matching polarity and phase
// [RQ14] while deselected, clock and data are ignored and shift state cleared
module adc_dac_serial_pin_logic
  import adc_dac_pins_pkg::*;
#(
  parameter int DAC_BITS = `CFG_DAC_BITS
) (
  // system
  input wire logic mclk,
  input wire logic reset_n,
  // serial pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  output logic dout,
  output logic doutEn,
  // control pins
  input wire logic convert_request_n,
  input wire logic dac_load_n,
  input wire logic dac_wake_level_select,
  output logic eocN,
  // core side
  input wire logic [1:0] clockMode,
  input wire logic externalTrigger,
  input wire logic [`CFG_TX_BITS-1:0] txWord,
  input wire logic conversionDone,
  input wire logic [DAC_BITS-1:0] dacCode,
  output logic [`CFG_BYTE_BITS-1:0] rxByte,
  output logic cmdValid,
  output logic dataValid,
  output logic frameEnd,
  output logic convertStart,
  output logic [DAC_BITS-1:0] dacOut,
  output logic dacWakeHigh
);

  // link logic runs on sclk; only the toggle, chip select and quasi-static words cross
  serial_link_if lk ();

  serial_link u_link (
    .reset_n(reset_n),
    .sclk(sclk),
    .csN(csN),
    .din(din),
    .dout(dout),
    .lk(lk.link)
  );

  // synchronisers: bit 0 cs, 1 request, 2 load, 3 wake, 4 byte toggle
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic csSeen;
  logic reqSeen;
  logic toggleSeen;
  logic wakeTaken;
  logic [1:0] modeHeld;
  logic [`CFG_TX_BITS-1:0] wordHeld;
  frame_state_t frameState;

  logic next_csSeen;
  logic next_reqSeen;
  logic next_toggleSeen;
  logic next_wakeTaken;
  logic [1:0] next_modeHeld;
  logic [`CFG_TX_BITS-1:0] next_wordHeld;
  frame_state_t next_frameState;
  logic next_doutEn;
  logic next_eocN;
  logic [`CFG_BYTE_BITS-1:0] next_rxByte;
  logic next_cmdValid;
  logic next_dataValid;
  logic next_frameEnd;
  logic next_convertStart;
  logic [DAC_BITS-1:0] next_dacOut;
  logic next_dacWakeHigh;

  logic byteArrived;
  logic csHigh;

  // word and mode only change while deselected, so the link sees them static
  assign lk.clockMode = modeHeld;
  assign lk.txWord = wordHeld;

  assign csHigh = sync2[0];
  // each flip of the link's toggle marks one finished byte; the byte itself
  // stands for eight sclk periods, so it is taken without a synchroniser of its own
  assign byteArrived = sync2[4] != toggleSeen;

  always_comb begin
    next_csSeen = csHigh;
    next_reqSeen = sync2[1];
    next_toggleSeen = sync2[4];
    next_modeHeld = modeHeld;
    next_wordHeld = wordHeld;
    next_frameState = frameState;
    // enable trails chip select by three mclk cycles, a limit on fast reselects
    next_doutEn = ~csHigh; // RQ3
    next_eocN = eocN;
    next_rxByte = rxByte;
    next_cmdValid = 1'h0;
    next_dataValid = 1'h0;
    next_frameEnd = 1'h0;
    next_convertStart = 1'h0;
    next_dacOut = dacOut;
    next_dacWakeHigh = dacWakeHigh;
    next_wakeTaken = 1'h1;

    // mode and reply word follow the core only while deselected
    if (csHigh) begin
      next_modeHeld = clockMode;
      next_wordHeld = txWord;
    end

    case (frameState)
      FRAME_IDLE: begin
        if (!csHigh && csSeen) // RQ11
          next_frameState = FRAME_CMD;
      end
      FRAME_CMD: begin
        // the first byte after the select is the command
        if (byteArrived) begin // RQ12
          next_rxByte = lk.rxByte;
          next_cmdValid = 1'h1;
          next_frameState = FRAME_DATA;
        end
      end
      FRAME_DATA: begin
        // length decoding is left to the core, so every later byte is data
        if (byteArrived) begin
          next_rxByte = lk.rxByte;
          next_dataValid = 1'h1;
        end
      end
      default: next_frameState = FRAME_IDLE;
    endcase
    // a byte that lands in the cycle the deselect is seen is still taken; any later one is lost
    if (csHigh && frameState != FRAME_IDLE) begin // RQ11 RQ5
      next_frameState = FRAME_IDLE;
      next_frameEnd = 1'h1;
    end

    // a falling request edge, seen after the synchroniser, starts one conversion when externalTrigger is set
    if (externalTrigger && reqSeen && !sync2[1]) // RQ10
      next_convertStart = 1'h1;

    // a new request clears the flag, completion wins if both land together
    if (next_convertStart)
      next_eocN = 1'h1;
    if (conversionDone)
      next_eocN = 1'h0; // RQ6

    // strap is read once after reset; fixed codes stand in for the pull levels
    if (!wakeTaken) begin // RQ9
      next_dacWakeHigh = sync2[3];
      next_dacOut = sync2[3] ? DAC_BITS'(`CFG_DAC_WAKE_HIGH) : DAC_BITS'(`CFG_DAC_WAKE_LOW);
    end else if (!sync2[2]) begin
      next_dacOut = dacCode; // RQ7 RQ8
    end
  end

  // the chain keeps sampling in reset, so the wake strap is settled at release
  always_ff @(posedge mclk) begin
    sync1 <= {lk.rxToggle, dac_wake_level_select, dac_load_n, convert_request_n, csN};
    sync2 <= sync1;
  end

  // every output below is a plain register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      csSeen <= `CFG_SYNC_RESET;
      reqSeen <= `CFG_SYNC_RESET;
      toggleSeen <= `CFG_SYNC_RESET;
      wakeTaken <= 1'h0;
      modeHeld <= 2'h0;
      wordHeld <= '0;
      frameState <= FRAME_IDLE;
      doutEn <= 1'h0;
      eocN <= `CFG_EOC_RESET;
      rxByte <= '0;
      cmdValid <= 1'h0;
      dataValid <= 1'h0;
      frameEnd <= 1'h0;
      convertStart <= 1'h0;
      dacOut <= '0;
      dacWakeHigh <= 1'h0;
    end else begin
      csSeen <= next_csSeen;
      reqSeen <= next_reqSeen;
      toggleSeen <= next_toggleSeen;
      wakeTaken <= next_wakeTaken;
      modeHeld <= next_modeHeld;
      wordHeld <= next_wordHeld;
      frameState <= next_frameState;
      doutEn <= next_doutEn;
      eocN <= next_eocN;
      rxByte <= next_rxByte;
      cmdValid <= next_cmdValid;
      dataValid <= next_dataValid;
      frameEnd <= next_frameEnd;
      convertStart <= next_convertStart;
      dacOut <= next_dacOut;
      dacWakeHigh <= next_dacWakeHigh;
    end
  end

endmodule

/* adc_dac_pins_cfg.svh */
`ifndef ADC_DAC_PINS_CFG_SVH
`define ADC_DAC_PINS_CFG_SVH

// serial framing
`define CFG_CMD_BITS 8
`define CFG_BYTE_BITS 8
`define CFG_TX_BITS 24
`define CFG_COUNT_BITS 5
`define CFG_COUNT_LAST_BIT 3'h7

// clock mode that moves the output on the rising edge
`define CFG_MODE_RISE 2'h3

// dac code width and its wake-up values
`define CFG_DAC_BITS 12
`define CFG_DAC_WAKE_LOW 12'h000
`define CFG_DAC_WAKE_HIGH 12'hFFF

// reset values
`define CFG_EOC_RESET 1'h1
`define CFG_SYNC_RESET 1'h1

// timing
`define CFG_MCLK_PERIOD_NS 20
`define CFG_MAX_SCLK_MHZ 25

`endif

/* adc_dac_pins_pkg.sv */
package adc_dac_pins_pkg;

  typedef enum logic [1:0] {
    MODE_INT_00 = 2'h0,
    MODE_INT_01 = 2'h1,
    MODE_INT_10 = 2'h2,
    MODE_EXT_11 = 2'h3
  } clock_mode_t;

  typedef enum logic [1:0] {
    FRAME_IDLE = 2'h0,
    FRAME_CMD  = 2'h1,
    FRAME_DATA = 2'h2
  } frame_state_t;

endpackage

/* serial_link_if.sv */
`timescale 1ns/1ps
`include "adc_dac_pins_cfg.svh"

interface serial_link_if;
  logic [1:0] clockMode;
  logic [`CFG_TX_BITS-1:0] txWord;
  logic [`CFG_BYTE_BITS-1:0] rxByte;
  logic rxToggle;

  modport link (
    input clockMode,
    input txWord,
    output rxByte,
    output rxToggle
  );

  modport core (
    output clockMode,
    output txWord,
    input rxByte,
    input rxToggle
  );
endinterface

/* serial_link.sv */
`timescale 1ns/1ps
`include "adc_dac_pins_cfg.svh"

module serial_link
  import adc_dac_pins_pkg::*;
(
  // reset
  input wire logic reset_n,
  // pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  output logic dout,
  // core side
  serial_link_if.link lk
);

  logic [`CFG_BYTE_BITS-1:0] rxShift;
  logic [`CFG_BYTE_BITS-1:0] next_rxShift;
  logic [`CFG_BYTE_BITS-1:0] next_rxByte;
  logic [`CFG_COUNT_BITS-1:0] bitCount;
  logic [`CFG_COUNT_BITS-1:0] next_bitCount;
  logic next_rxToggle;
  logic doutNeg;
  logic doutPos;
  logic next_doutNeg;
  logic next_doutPos;

  // bits past the reply read as zero
  function automatic logic txBit(input logic [`CFG_TX_BITS-1:0] word, input logic [`CFG_COUNT_BITS-1:0] idx);
    logic [`CFG_COUNT_BITS-1:0] pos;
    pos = 5'(`CFG_TX_BITS - 1) - idx;
    if (idx < 5'(`CFG_TX_BITS))
      return word[pos];
    else
      return 1'h0;
  endfunction

  always_comb begin
    next_rxShift = {rxShift[`CFG_BYTE_BITS-2:0], din}; // RQ4
    next_bitCount = bitCount + 5'h01;
    next_rxByte = lk.rxByte;
    next_rxToggle = lk.rxToggle;
    if (bitCount[2:0] == `CFG_COUNT_LAST_BIT) begin // RQ12
      next_rxByte = next_rxShift;
      next_rxToggle = ~lk.rxToggle;
    end
    if (bitCount == 5'h1F)
      next_bitCount = bitCount;
    next_doutNeg = txBit(lk.txWord, bitCount);
    next_doutPos = txBit(lk.txWord, bitCount);
  end

  // chip select high holds the shift register, bit count, byte and falling-edge output cleared
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin // RQ14 RQ11
      rxShift <= '0;
      bitCount <= '0;
      lk.rxByte <= '0;
      doutNeg <= 1'h0;
    end else begin // RQ5
      rxShift <= next_rxShift;
      bitCount <= next_bitCount;
      lk.rxByte <= next_rxByte;
      doutNeg <= next_doutNeg; // RQ1
    end
  end

  // toggle survives chip select so the core never sees a false byte;
  // its reset level matches the core's idea of an idle toggle
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n)
      lk.rxToggle <= `CFG_SYNC_RESET;
    else
      lk.rxToggle <= next_rxToggle;
  end

  always_ff @(posedge sclk or posedge csN) begin
    if (csN)
      doutPos <= 1'h0;
    else
      doutPos <= next_doutPos; // RQ2
  end

  assign dout = (lk.clockMode == `CFG_MODE_RISE) ? doutPos : doutNeg; // RQ1 RQ2

endmodule

/* adc_dac_pins_properties.sv */
`timescale 1ns/1ps
module adc_dac_pins_properties #(
  parameter int DAC_BITS = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // serial side
  input wire logic csN,
  input wire logic doutEn,
  input wire logic frameEnd,
  // control side
  input wire logic convert_request_n,
  input wire logic externalTrigger,
  input wire logic convertStart,
  input wire logic conversionDone,
  input wire logic eocN,
  // dac side
  input wire logic dac_load_n,
  input wire logic [DAC_BITS-1:0] dacCode,
  input wire logic [DAC_BITS-1:0] dacOut,
  input wire logic dacWakeHigh,
  input wire logic dac_wake_level_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  idle_release_a: assert property (csN [*4] |-> !doutEn) else $error("dout not released");
  select_drive_a: assert property (!csN [*4] |-> doutEn) else $error("dout not driven");
  frame_end_a: assert property ($rose(csN) |-> ##[2:6] frameEnd) else $error("no frame end");
  conv_start_a: assert property ($fell(convert_request_n) && externalTrigger |-> ##[2:4] convertStart)
    else $error("no start");
  eoc_set_a: assert property (conversionDone |=> !eocN) else $error("eoc not low");
  eoc_clear_a: assert property (convertStart && !conversionDone |=> eocN) else $error("eoc not high");
  dac_hold_a: assert property (dac_load_n [*4] |=> $stable(dacOut)) else $error("dac moved");
  dac_pass_a: assert property ((!dac_load_n && $stable(dacCode)) [*6] |-> dacOut == dacCode)
    else $error("dac not passed");
  wake_level_a: assert property ($rose(reset_n) |=> dacWakeHigh == dac_wake_level_select)
    else $error("bad wake level");
endmodule

bind adc_dac_serial_pin_logic adc_dac_pins_properties #(.DAC_BITS(DAC_BITS)) u_props (.mclk, .reset_n, .csN,
  .doutEn, .frameEnd, .convert_request_n, .externalTrigger, .convertStart, .conversionDone, .eocN, .dac_load_n,
  .dacCode, .dacOut, .dacWakeHigh, .dac_wake_level_select);

/* spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  // pins
  output logic sclk,
  output logic csN,
  output logic din,
  input wire logic doutPin,
  // setup
  input wire logic [1:0] mode
);
  initial begin
    sclk = 1'h0;
    csN = 1'h1;
    din = 1'h0;
  end
  // 160 ns period, idles low; odd start keeps it off the mclk phase
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    // clock and data noise while deselected must leave the next frame untouched
    repeat (3) begin
      #80 din = ~din;
      sclk = 1'h1;
      #80 sclk = 1'h0;
    end
    #7 csN = 1'h0;
    #120;
    for (int k = 0; k < 24; k++) begin
      #40 if (k > 0 && mode != 2'h3) rx[24-k] = doutPin;
      din = tx[23-k];
      #40 sclk = 1'h1;
      #40 if (mode == 2'h3) rx[23-k] = doutPin;
      #40 sclk = 1'h0;
    end
    #40 if (mode != 2'h3) rx[0] = doutPin;
    din = ~din;
    #40 csN = 1'h1;
    #120;
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'h0;
  logic reset_n, sclk, csN, din, dout, doutEn, doutPin, eocN, cmdValid, dataValid, frameEnd;
  logic convert_request_n, dac_load_n, dac_wake_level_select, externalTrigger, conversionDone;
  logic convertStart, dacWakeHigh;
  logic [1:0] clockMode;
  logic [23:0] txWord;
  logic [11:0] dacCode, dacOut;
  logic [7:0] rxByte;
  logic [8:0] rxq[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int frames = 0;
  // released line shows the inverse so a stale bit cannot pass
  assign doutPin = doutEn ? dout : ~dout;
  always #10 mclk = ~mclk;
  adc_dac_serial_pin_logic u_dut (.mclk, .reset_n, .sclk, .csN, .din, .dout, .doutEn, .convert_request_n,
    .dac_load_n, .dac_wake_level_select, .eocN, .clockMode, .externalTrigger, .txWord, .conversionDone,
    .dacCode, .rxByte, .cmdValid, .dataValid, .frameEnd, .convertStart, .dacOut, .dacWakeHigh);
  spi_master_model u_master (.sclk, .csN, .din, .doutPin, .mode(clockMode));
  task automatic check(input logic [23:0] seen, input logic [23:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cmdValid === 1'h1 || dataValid === 1'h1) rxq.push_back({cmdValid, rxByte});
    if (frameEnd === 1'h1) frames++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic reset_dut(input logic strap);
    reset_n = 1'h0;
    dac_wake_level_select = strap;
    repeat (3) @(negedge mclk);
    reset_n = 1'h1;
    repeat (4) @(negedge mclk);
    check(dacWakeHigh, strap);
    check(dacOut, strap ? 12'hFFF : 12'h000);
  endtask
  task automatic frame_test(input logic [1:0] mode, input logic [23:0] word);
    logic [23:0] sent;
    logic [23:0] reply;
    sent = {word[11:0], word[23:12]};
    clockMode = mode;
    txWord = word;
    rxq.delete();
    frames = 0;
    // mode and reply word are only taken while deselected
    repeat (4) @(negedge mclk);
    u_master.xfer(sent, reply);
    repeat (8) @(negedge mclk);
    check(reply, word);
    check(rxq.size(), 3);
    for (int i = 0; i < 3; i++) begin
      check(rxq[i], {i == 0, sent[23-8*i -: 8]});
    end
    check(frames, 1);
    check(doutEn, 1'h0);
  endtask
  task automatic convert_test();
    int n;
    // pull the flag low first so that the request has something to clear
    conversionDone = 1'h1;
    @(negedge mclk);
    conversionDone = 1'h0;
    check(eocN, 1'h0);
    externalTrigger = 1'h1;
    convert_request_n = 1'h0;
    n = 0;
    while (convertStart !== 1'h1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    check(n < 10, 1'h1);
    convert_request_n = 1'h1;
    @(negedge mclk);
    check(eocN, 1'h1);
    conversionDone = 1'h1;
    @(negedge mclk);
    conversionDone = 1'h0;
    check(eocN, 1'h0);
    externalTrigger = 1'h0;
    convert_request_n = 1'h0;
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      n += (convertStart === 1'h1);
    end
    convert_request_n = 1'h1;
    check(n, 0);
  endtask
  task automatic dac_test(input logic [11:0] code, input logic load, input logic [11:0] expected);
    dac_load_n = load;
    repeat (4) @(negedge mclk);
    dacCode = code;
    repeat (6) @(negedge mclk);
    check(dacOut, expected);
  endtask
  initial begin
    {reset_n, externalTrigger, conversionDone} = 3'h0;
    {convert_request_n, dac_load_n} = 2'h3;
    clockMode = 2'h0;
    txWord = 24'h0;
    dacCode = 12'h0;
    reset_dut(1'h1);
    for (int m = 0; m < 4; m++) begin
      frame_test(2'(m), 24'hC35A96 ^ 24'(m));
    end
    convert_test();
    dac_test(12'h5A3, 1'h1, 12'hFFF);
    dac_test(12'h5A3, 1'h0, 12'h5A3);
    dac_test(12'h0C7, 1'h0, 12'h0C7);
    dac_test(12'hF00, 1'h1, 12'h0C7);
    reset_dut(1'h0);
    frame_test(2'h0, 24'h3CF018);
    conclude();
  end
endmodule
